// File: src/sta_consts.vh
// Purpose: Constants for the synchronous tandem adjustment block
// Assumes: 12-bit normalized log magnitude, 8-bit companded PCM words
// Notes:   Definitions only
`ifndef STA_CONSTS_VH
`define STA_CONSTS_VH

// Rate select codes
`define STA_RATE_32          2'h0
`define STA_RATE_24          2'h1
`define STA_RATE_16          2'h2

// Log magnitude boundaries, 32 kbit/s
`define STA_R32_T0           12'h0_050
`define STA_R32_T1           12'h0_0B2
`define STA_R32_T2           12'h0_0F6
`define STA_R32_T3           12'h0_12C
`define STA_R32_T4           12'h0_15D
`define STA_R32_T5           12'h0_190
`define STA_R32_NEG          12'hF_84
// Log magnitude boundaries, 24 kbit/s
`define STA_R24_T0           12'h0_008
`define STA_R24_T1           12'h0_0DA
`define STA_R24_T2           12'h0_14B
// Log magnitude boundary, 16 kbit/s
`define STA_R16_T0           12'h1_05
// Start of the negative log range
`define STA_LOG_NEG          12'h8_00

// Reset value of the output word
`define STA_PCM_RST          8'h0_0
// Even bit inversion mask for A-law
`define STA_ALAW_MASK        8'h5_5
// Extreme sign-magnitude codes
`define STA_MAG_MAX          7'h7_F

`endif

// File: src/sta_pcm_step.v
// Purpose: Step a companded PCM word one level up or down
// Assumes: Sign-magnitude form after law correction
// Notes:   Saturates at both extreme levels
`timescale 1ns/10ps
`include "sta_consts.vh"

module sta_pcm_step
(
    input  wire       law_alaw,
    input  wire [7:0] pcm_in,
    input  wire       step_up,
    input  wire       step_dn,
    output reg  [7:0] pcm_out
);

    reg       pos;
    reg [6:0] mag;
    reg [7:0] sm;
    reg [7:0] raw;

    always @*
    begin
        // To sign-magnitude: pos=1 positive, mag grows with level
        // Mu-law zero codes share one level, so zero crossings skip a code
        if (law_alaw)
        begin
            raw = pcm_in ^ `STA_ALAW_MASK;      // RULE14
            pos = raw[7];
            mag = raw[6:0];
        end
        else
        begin
            raw = pcm_in;
            pos = raw[7];
            mag = ~raw[6:0];
        end
        sm = {pos, mag};
        if (step_up)
        begin
            if (pos && mag == `STA_MAG_MAX)
                sm = {pos, mag};                // RULE9
            else if (pos)
                sm = {1'b1, mag + 7'h0_1};
            else if (mag == 7'h0_0)
                sm = law_alaw ? 8'h8_0 : 8'h8_1; // RULE14
            else
                sm = {1'b0, mag - 7'h0_1};
        end
        else if (step_dn)
        begin
            if (!pos && mag == `STA_MAG_MAX)
                sm = {pos, mag};                // RULE9
            else if (!pos)
                sm = {1'b0, mag + 7'h0_1};
            else if (mag == 7'h0_0)
                sm = law_alaw ? 8'h0_0 : 8'h0_1; // RULE14
            else
                sm = {1'b1, mag - 7'h0_1};
        end
        if (law_alaw)
            pcm_out = sm ^ `STA_ALAW_MASK;
        else
            pcm_out = {sm[7], ~sm[6:0]};
    end

endmodule // sta_pcm_step

// File: src/sta_sync_adjust.v
// Purpose: Decoder synchronous coding adjustment of the PCM output word
// Assumes: Inputs synchronous to clk; one sample per sample_valid pulse
// Notes:   Result registered one cycle after sample_valid
//
// Behaviour
// RULE1: 32k positive sign maps log ranges to index 15..9, else 7.
// RULE2: 32k negative sign maps log ranges to 7, 6, then 5..0.
// RULE3: 24k sign is codeword bit 2; reference is codeword+4 or low bits.
// RULE4: 24k positive sign gives index 7, 6, 5 or 3.
// RULE5: 24k negative sign gives index 3, 2, 1 or 0.
// RULE6: 16k sign is codeword bit 1; reference is codeword+2 or low bit.
// RULE7: 16k index is 3/2 for positive sign, 1/0 for negative.
// RULE8: Index below reference steps up, equal keeps, above steps down.
// RULE9: Steps saturate at the most positive and most negative levels.
// RULE10: Encoder and decoder must run at the same coding rate.
// RULE11: 32k sign is codeword bit 3; reference is codeword+8 or low bits.
// RULE12: Log magnitude input is scale-normalized 12-bit decoder form.
// RULE13: Rate select picks table and width; output once per sample.
// RULE14: Stepping follows law ordering, zero crossing and A-law inversion.
`timescale 1ns/10ps
`include "sta_consts.vh"

module sta_sync_adjust
(
    input  wire        clk,
    input  wire        reset,
    input  wire [1:0]  rate_sel,
    input  wire        law_alaw,
    input  wire        sample_valid,
    input  wire [3:0]  adpcm_codeword,
    input  wire [7:0]  compressed_pcm_word,
    input  wire        reencode_diff_sign,
    input  wire [11:0] reencode_norm_log_mag,
    output reg  [7:0]  adjusted_pcm_out,
    output reg         adjusted_valid
);

    reg  [4:0]  decision_index;
    reg  [4:0]  code_magnitude_ref;
    reg         code_sign_bit;
    reg         step_up;
    reg         step_dn;
    wire [7:0]  stepped_pcm;
    wire [11:0] dl;
    wire        neg_range;

    assign dl        = reencode_norm_log_mag;        // RULE12
    assign neg_range = dl >= `STA_LOG_NEG;

    ////////////////////////////////////////////////////////////////////////
    // Sign and magnitude reference from the codeword
    always @*
    begin
        code_sign_bit      = 1'b0;
        code_magnitude_ref = 5'h0_0;
        case (rate_sel)                              // RULE13
            `STA_RATE_32:
            begin
                code_sign_bit      = adpcm_codeword[3];  // RULE11
                code_magnitude_ref = code_sign_bit ? {2'b00, adpcm_codeword[2:0]}
                                   : {1'b0, adpcm_codeword} + 5'h0_8;
            end
            `STA_RATE_24:
            begin
                code_sign_bit      = adpcm_codeword[2];  // RULE3
                code_magnitude_ref = code_sign_bit ? {3'b000, adpcm_codeword[1:0]}
                                   : {2'b00, adpcm_codeword[2:0]} + 5'h0_4;
            end
            `STA_RATE_16:
            begin
                code_sign_bit      = adpcm_codeword[1];  // RULE6
                code_magnitude_ref = code_sign_bit ? {4'h0, adpcm_codeword[0]}
                                   : {3'b000, adpcm_codeword[1:0]} + 5'h0_2;
            end
            default:
            begin
                code_sign_bit      = 1'b0;
                code_magnitude_ref = 5'h0_0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Decision index from re-encoded difference
    always @*
    begin
        decision_index = 5'h0_0;
        case (rate_sel)                              // RULE10
            `STA_RATE_32:
            begin
                if (!reencode_diff_sign)             // RULE1
                begin
                    if (neg_range)
                        decision_index = (dl >= `STA_R32_NEG) ? 5'h0_9 : 5'h0_7;
                    else if (dl >= `STA_R32_T5) decision_index = 5'h0_F;
                    else if (dl >= `STA_R32_T4) decision_index = 5'h0_E;
                    else if (dl >= `STA_R32_T3) decision_index = 5'h0_D;
                    else if (dl >= `STA_R32_T2) decision_index = 5'h0_C;
                    else if (dl >= `STA_R32_T1) decision_index = 5'h0_B;
                    else if (dl >= `STA_R32_T0) decision_index = 5'h0_A;
                    else                        decision_index = 5'h0_9;
                end
                else                                 // RULE2
                begin
                    if (neg_range)
                        decision_index = (dl >= `STA_R32_NEG) ? 5'h0_6 : 5'h0_7;
                    else if (dl >= `STA_R32_T5) decision_index = 5'h0_0;
                    else if (dl >= `STA_R32_T4) decision_index = 5'h0_1;
                    else if (dl >= `STA_R32_T3) decision_index = 5'h0_2;
                    else if (dl >= `STA_R32_T2) decision_index = 5'h0_3;
                    else if (dl >= `STA_R32_T1) decision_index = 5'h0_4;
                    else if (dl >= `STA_R32_T0) decision_index = 5'h0_5;
                    else                        decision_index = 5'h0_6;
                end
            end
            `STA_RATE_24:
            begin
                if (!reencode_diff_sign)             // RULE4
                begin
                    if (neg_range)                   decision_index = 5'h0_3;
                    else if (dl >= `STA_R24_T2)      decision_index = 5'h0_7;
                    else if (dl >= `STA_R24_T1)      decision_index = 5'h0_6;
                    else if (dl >= `STA_R24_T0)      decision_index = 5'h0_5;
                    else                             decision_index = 5'h0_3;
                end
                else                                 // RULE5
                begin
                    if (neg_range)                   decision_index = 5'h0_3;
                    else if (dl >= `STA_R24_T2)      decision_index = 5'h0_0;
                    else if (dl >= `STA_R24_T1)      decision_index = 5'h0_1;
                    else if (dl >= `STA_R24_T0)      decision_index = 5'h0_2;
                    else                             decision_index = 5'h0_3;
                end
            end
            `STA_RATE_16:
            begin
                if (!neg_range && dl >= `STA_R16_T0) // RULE7
                    decision_index = reencode_diff_sign ? 5'h0_0 : 5'h0_3;
                else
                    decision_index = reencode_diff_sign ? 5'h0_1 : 5'h0_2;
            end
            default:
                decision_index = 5'h0_0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Comparison and stepping
    always @*
    begin
        step_up = decision_index < code_magnitude_ref;  // RULE8
        step_dn = decision_index > code_magnitude_ref;  // RULE8
    end

    sta_pcm_step u_step
    (
        .law_alaw (law_alaw),
        .pcm_in   (compressed_pcm_word),
        .step_up  (step_up),
        .step_dn  (step_dn),
        .pcm_out  (stepped_pcm)
    );

    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            adjusted_pcm_out <= `STA_PCM_RST;
            adjusted_valid   <= 1'b0;
        end
        else
        begin
            adjusted_valid <= sample_valid;         // RULE13
            if (sample_valid)
                adjusted_pcm_out <= stepped_pcm;
        end
    end

endmodule // sta_sync_adjust

// File: dv/sta_sync_adjust_props.sv
// Purpose: Port assertions for the tandem adjust block
// Assumes: One clock, asynchronous active-high reset
// Notes:   Attached by the bind below
`timescale 1ns/10ps

module sta_sync_adjust_props
(
    input wire        clk,
    input wire        reset,
    input wire [1:0]  rate_sel,
    input wire        law_alaw,
    input wire        sample_valid,
    input wire [3:0]  adpcm_codeword,
    input wire [7:0]  compressed_pcm_word,
    input wire        reencode_diff_sign,
    input wire [11:0] reencode_norm_log_mag,
    input wire [7:0]  adjusted_pcm_out,
    input wire        adjusted_valid
);
    wire [11:0] mg  = reencode_norm_log_mag;
    wire [3:0]  cw  = adpcm_codeword;
    wire [7:0]  sp  = compressed_pcm_word;
    wire [7:0]  so  = adjusted_pcm_out;
    wire        sv  = sample_valid;
    wire        k32 = rate_sel == 2'h0 && cw == 4'hF && mg[11] && mg < 12'hF_84;
    wire        k24 = rate_sel == 2'h1 && cw[2:0] == 3'h7 && mg[11];
    wire        k16 = rate_sel == 2'h2 && cw[1:0] == 2'h1 && !reencode_diff_sign
                      && !mg[11] && mg > 12'h1_04;
    wire        k32d = rate_sel == 2'h0 && cw == 4'h8 && mg[11] && mg < 12'hF_84;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    ////////////////////////////////
    valid_follows_a: assert property (sv |=> adjusted_valid)
        else $error("no strobe after sample");
    strobe_cause_a: assert property (adjusted_valid |-> $past(sv))
        else $error("strobe without sample");
    out_hold_a: assert property (!sv |=> $stable(so))
        else $error("output moved without sample");
    keep_rate32_a: assert property (sv && k32 |=> so == $past(sp))
        else $error("32k equal case changed word");
    keep_rate24_a: assert property (sv && k24 |=> so == $past(sp))
        else $error("24k equal case changed word");
    keep_rate16_a: assert property (sv && k16 |=> so == $past(sp))
        else $error("16k equal case changed word");
    mu_top_a: assert property (sv && !law_alaw && sp == 8'h8_0 |=> so inside {8'h8_0, 8'h8_1})
        else $error("mu-law top level overstepped");
    a_top_a: assert property (sv && law_alaw && sp == 8'hA_A |=> so inside {8'hA_A, 8'hA_B})
        else $error("A-law top level overstepped");
    mu_zero_a: assert property (sv && k32d && !law_alaw && sp == 8'hF_F |=> so == 8'h7_E)
        else $error("mu-law zero not stepped to minus one");
    a_zero_a: assert property (sv && k32d && law_alaw && sp == 8'hD_5 |=> so == 8'h5_5)
        else $error("A-law zero not stepped to minus zero");
endmodule // sta_sync_adjust_props

bind sta_sync_adjust sta_sync_adjust_props u_props (.*);

// File: dv/sta_dec_src.sv
// Purpose: Decoder datapath source, one sample per request
// Assumes: Requests change just after a rising edge
// Notes:   Sample fields other than rate and law are scrambled between samples
`timescale 1ns/10ps

module sta_dec_src
(
    input  wire        clk,
    input  wire        go,
    input  wire [27:0] f,
    output reg  [1:0]  rate_sel = 2'h0,
    output reg         law_alaw = 1'b0,
    output reg         sample_valid = 1'b0,
    output reg  [3:0]  adpcm_codeword = 4'h0,
    output reg  [7:0]  compressed_pcm_word = 8'h0_0,
    output reg         reencode_diff_sign = 1'b0,
    output reg  [11:0] reencode_norm_log_mag = 12'h0_00
);
    // Rate and law move only with a sample, so both ends share one rate
    always @(posedge clk)
    begin
        sample_valid <= go;
        if (go)
            {rate_sel, law_alaw, adpcm_codeword, compressed_pcm_word, reencode_diff_sign,
             reencode_norm_log_mag} <= f;
        else
            {adpcm_codeword, compressed_pcm_word, reencode_diff_sign, reencode_norm_log_mag}
                <= ~{adpcm_codeword, compressed_pcm_word, reencode_diff_sign,
                     reencode_norm_log_mag};
    end
endmodule // sta_dec_src

// File: dv/sta_sync_adjust_tb_top.sv
// Purpose: Self-checking bench for the tandem adjust block
// Assumes: 10 MHz clock, reset held five cycles
// Notes:   Samples reach the block through the source model
`timescale 1ns/10ps

module sta_sync_adjust_tb_top;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        go = 1'b0;
    logic [27:0] f = 28'h000_0000;
    logic [1:0]  rate_sel;
    logic        law_alaw, sample_valid, reencode_diff_sign, adjusted_valid;
    logic [3:0]  adpcm_codeword;
    logic [7:0]  compressed_pcm_word, adjusted_pcm_out;
    logic [11:0] reencode_norm_log_mag;
    int          fail_count = 0;
    int          checked = 0;
    localparam int BND [26] = '{0, 7, 8, 79, 80, 177, 178, 217, 218, 245, 246, 260, 261,
        299, 300, 330, 331, 348, 349, 399, 400, 2047, 2048, 3971, 3972, 4095};
    localparam logic [23:0] STV [18] = '{24'h1D_5855, 24'h1D_5FD5, 24'h1D_50D4,
        24'h15_5854, 24'h15_50D5, 24'h15_4857, 24'h15_4055, 24'h1A_A0AA, 24'h12_A82A,
        24'h0F_E8FF, 24'h0F_E0FD, 24'h0F_F87E, 24'h0F_F0FE, 24'h07_E87D, 24'h07_E07F,
        24'h08_0080, 24'h00_0800, 24'h07_F0FE};

    sta_dec_src     src (.*);
    sta_sync_adjust dut (.*);

    initial forever #50 clk = ~clk;
    ////////////////////////////////
    task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
        checked++;
        if (s !== e)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic results();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    function automatic logic [3:0] exp_id(logic [1:0] r, logic d, int m);
        int k;
        if (r == 2'h0)
        begin
            if (m >= 2048 && m <= 3971) return 4'h7;
            k = m >= 3972 || m < 80 ? 9 : m >= 400 ? 15 : m >= 349 ? 14 : m >= 300 ? 13 :
                m >= 246 ? 12 : m >= 178 ? 11 : 10;
            return 4'(d ? 15 - k : k);
        end
        if (r == 2'h1)
        begin
            if (m >= 2048 || m < 8) return 4'h3;
            k = m >= 331 ? 7 : m >= 218 ? 6 : 5;
            return 4'(d ? 7 - k : k);
        end
        k = m >= 261 && m < 2048 ? 3 : 2;
        return 4'(d ? 3 - k : k);
    endfunction

    task automatic smp(logic [27:0] v, logic [7:0] e);
        @(posedge clk);
        go <= 1'b1;
        f <= v;
        @(posedge clk);
        go <= 1'b0;
        for (int n = 0; n < 4 && adjusted_valid !== 1'b1; n++)
            @(posedge clk) #1;
        chk("valid", {7'h00, adjusted_valid}, 8'h0_1);
        chk("pcm", adjusted_pcm_out, e);
    endtask

    task automatic sweep(logic [1:0] r, int w, logic lw, logic [7:0] sp, su, sd);
        logic [3:0] id;
        logic [4:0] im;
        for (int i = 0; i < 26; i++)
            for (int d = 0; d < 2; d++)
                for (int c = 0; c < (1 << w); c++)
                begin
                    id = exp_id(r, d[0], BND[i]);
                    im = c[w-1] ? 5'(c & ((1 << (w - 1)) - 1)) : 5'(c + (1 << (w - 1)));
                    smp({r, lw, 4'(c), sp, d[0], 12'(BND[i])},
                        id < im ? su : id > im ? sd : sp);
                end
    endtask

    task automatic t_r32();
        sweep(2'h0, 4, 1'b0, 8'hC_0, 8'hB_F, 8'hC_1);
    endtask

    task automatic t_r24();
        sweep(2'h1, 3, 1'b1, 8'hC_0, 8'hC_3, 8'hC_1);
    endtask

    task automatic t_r16();
        sweep(2'h2, 2, 1'b0, 8'h4_0, 8'h4_1, 8'h3_F);
    endtask

    task automatic t_step();
        foreach (STV[i])
            smp({2'h0, STV[i][20], STV[i][11:8], STV[i][19:12], 1'b0, 12'hB_B8},
                STV[i][7:0]);
    endtask

    task automatic t_rst();
        smp({2'h3, 1'b0, 4'h0, 8'hC_0, 1'b1, 12'h0_00}, 8'hC_0);
        smp({2'h0, 1'b0, 4'h0, 8'hC_0, 1'b0, 12'hB_B8}, 8'hB_F);
        @(posedge clk);
        reset <= 1'b1;
        @(posedge clk) #1;
        chk("pcm", adjusted_pcm_out, 8'h0_0);
        chk("valid", {7'h00, adjusted_valid}, 8'h0_0);
        @(posedge clk);
        reset <= 1'b0;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        results();
    end

    initial
    begin
        repeat (5) @(posedge clk);
        chk("pcm", adjusted_pcm_out, 8'h0_0);
        chk("valid", {7'h00, adjusted_valid}, 8'h0_0);
        reset <= 1'b0;
        t_r32();
        t_r24();
        t_r16();
        t_step();
        t_rst();
        t_step();
        results();
    end
endmodule // sta_sync_adjust_tb_top
